// *** shared/lfa_regs.vh ***
// lfa_regs.vh: constants for the literal/file alu datapath
// assumes inclusion by bare name from core files
`ifndef LFA_REGS_VH
`define LFA_REGS_VH
// operation codes presented by the decoder
`define LFA_OP_NOP 3'h0
`define LFA_OP_ADDLIT 3'h1
`define LFA_OP_ADDFILE 3'h2
`define LFA_OP_ANDFILE 3'h3
`define LFA_OP_ANDLIT 3'h4
`define LFA_OP_BITCLR 3'h5
`define LFA_OP_BITSET 3'h6
// destination select values
`define LFA_DEST_ACC 1'b0
`define LFA_DEST_FILE 1'b1
// status flag positions in the flag bus
`define LFA_FLAG_C 0
`define LFA_FLAG_DC 1
`define LFA_FLAG_Z 2
// reset values
`define LFA_ACC_RST 8'h00
`define LFA_FLAGS_RST 3'h0
`define LFA_ADDR_RST 7'h00
`endif

// *** core/lfa_adder.v ***
// lfa_adder.v: 8-bit adder with nibble carry split
// assumes purely combinational use by the datapath
`include "lfa_regs.vh"
module lfa_adder
#(
    parameter WIDTH = 8
)
(
    input wire [WIDTH-1:0] a,
    input wire [WIDTH-1:0] b,
    output wire [WIDTH-1:0] sum,
    output wire carry,
    output wire half_carry
)
;
    wire [4:0] lo_sum;
    wire [WIDTH-4:0] hi_sum;

    // low nibble first so its carry is visible for the digit flag
    assign lo_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    assign hi_sum = {1'b0, a[WIDTH-1:4]} + {1'b0, b[WIDTH-1:4]} + {{(WIDTH-4){1'b0}}, lo_sum[4]};
    assign sum = {hi_sum[WIDTH-5:0], lo_sum[3:0]};
    assign carry = hi_sum[WIDTH-4];
    assign half_carry = lo_sum[4];
endmodule // lfa_adder

// *** core/lfa_alu.v ***
// lfa_alu.v: execute stage for literal/file add, and, bit set/clear
// assumes decoder gives one op pulse with operands, file data already read
//
// Contract
// - add literal to accumulator, flags c dc z
// - add accumulator and file, flags c dc z
// - destination 0 accumulator, 1 file register
// - and accumulator with file, zero flag only
// - and literal into accumulator, zero only
// - bit clear file bit, flags unchanged
// - bit set file bit, flags unchanged
`include "lfa_regs.vh"
module lfa_alu
#(
    parameter WIDTH = 8,
    parameter AW = 7
)
(
    input wire ref_clk,
    input wire rst_n,
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [WIDTH-1:0] literal,
    input wire [AW-1:0] file_addr,
    input wire dest_sel,
    input wire [2:0] bit_sel,
    input wire [WIDTH-1:0] file_rdata,
    output reg [WIDTH-1:0] acc_r,
    output reg [2:0] flags_r,
    output reg file_we_r,
    output reg [AW-1:0] file_waddr_r,
    output reg [WIDTH-1:0] file_wdata_r,
    output reg done_r
)
;
    reg [WIDTH-1:0] acc_nxt;
    reg [2:0] flags_nxt;
    reg file_we_nxt;
    reg [AW-1:0] file_waddr_nxt;
    reg [WIDTH-1:0] file_wdata_nxt;
    reg done_nxt;
    // decoded instruction strobes, only ever high together with op_valid
    reg is_add_literal_to_acc;
    reg is_add_acc_and_file;
    reg is_and_acc_with_file;
    reg is_and_literal_into_acc;
    reg is_bit_clear_file;
    reg is_bit_set_file;
    reg is_file_form;
    // datapath intermediates
    reg [WIDTH-1:0] add_b;
    reg [WIDTH-1:0] and_res;
    reg [WIDTH-1:0] file_op_res;
    reg [WIDTH-1:0] bit_mask;
    reg add_zero;
    reg and_zero;
    wire [WIDTH-1:0] sum;
    wire carry;
    wire half_carry;

    // instruction decode; codes 0 and 7 raise no strobe at all
    always @*
    begin
        is_add_literal_to_acc = 1'b0;
        is_add_acc_and_file = 1'b0;
        is_and_acc_with_file = 1'b0;
        is_and_literal_into_acc = 1'b0;
        is_bit_clear_file = 1'b0;
        is_bit_set_file = 1'b0;
        if (op_valid)
        begin
            case (op_code)
                `LFA_OP_ADDLIT:
                begin
                    is_add_literal_to_acc = 1'b1;
                end
                `LFA_OP_ADDFILE:
                begin
                    is_add_acc_and_file = 1'b1;
                end
                `LFA_OP_ANDFILE:
                begin
                    is_and_acc_with_file = 1'b1;
                end
                `LFA_OP_ANDLIT:
                begin
                    is_and_literal_into_acc = 1'b1;
                end
                `LFA_OP_BITCLR:
                begin
                    is_bit_clear_file = 1'b1;
                end
                `LFA_OP_BITSET:
                begin
                    is_bit_set_file = 1'b1;
                end
                default:
                begin
                    // nop and spare code: done still pulses and the write address loads, nothing else moves
                    is_bit_set_file = 1'b0;
                end
            endcase
        end
        is_file_form = is_add_acc_and_file | is_and_acc_with_file;
    end

    // one adder serves both add forms; a mux is cheaper than a second adder
    always @*
    begin
        if (is_add_literal_to_acc)
        begin
            add_b = literal;
        end
        else
        begin
            add_b = file_rdata;
        end
    end

    lfa_adder #(.WIDTH(WIDTH)) u_add
    (
        .a(acc_r),
        .b(add_b),
        .sum(sum),
        .carry(carry),
        .half_carry(half_carry)
    );

    // one row of and gates for the literal and the file form
    always @*
    begin
        if (is_and_literal_into_acc)
        begin
            and_res = acc_r & literal;
        end
        else
        begin
            and_res = acc_r & file_rdata;
        end
    end

    // result of the file-sourced forms before destination steering
    always @*
    begin
        if (is_add_acc_and_file)
        begin
            file_op_res = sum;
        end
        else
        begin
            file_op_res = and_res;
        end
    end

    // one-hot mask of the selected bit
    always @*
    begin
        bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << bit_sel;
    end

    // zero detect kept per path so the flag never sees the wrong unit
    always @*
    begin
        add_zero = (sum == {WIDTH{1'b0}});
        and_zero = (and_res == {WIDTH{1'b0}});
    end

    // accumulator: literal forms always, file forms only when d is 0
    always @*
    begin
        acc_nxt = acc_r;
        if (is_add_literal_to_acc)
        begin
            acc_nxt = sum;
        end
        else if (is_and_literal_into_acc)
        begin
            acc_nxt = and_res;
        end
        else if (is_file_form && dest_sel == `LFA_DEST_ACC)
        begin
            acc_nxt = file_op_res;
        end
    end

    // flags: adds touch all three, ands only zero
    always @*
    begin
        flags_nxt = flags_r;
        if (is_add_literal_to_acc || is_add_acc_and_file)
        begin
            flags_nxt[`LFA_FLAG_C] = carry;
            flags_nxt[`LFA_FLAG_DC] = half_carry;
            flags_nxt[`LFA_FLAG_Z] = add_zero;
        end
        else if (is_and_literal_into_acc || is_and_acc_with_file)
        begin
            flags_nxt[`LFA_FLAG_Z] = and_zero;
        end
        // bit set and clear fall through, status kept
    end

    // file write; file_rdata must already carry any write still in flight,
    // this block does no forwarding of its own
    always @*
    begin
        file_we_nxt = 1'b0;
        file_wdata_nxt = file_wdata_r;
        if (is_bit_clear_file)
        begin
            file_we_nxt = 1'b1;
            file_wdata_nxt = file_rdata & ~bit_mask;
        end
        else if (is_bit_set_file)
        begin
            file_we_nxt = 1'b1;
            file_wdata_nxt = file_rdata | bit_mask;
        end
        else if (is_file_form && dest_sel == `LFA_DEST_FILE)
        begin
            file_we_nxt = 1'b1;
            file_wdata_nxt = file_op_res;
        end
    end

    // address and done follow every accepted op, spare codes included
    always @*
    begin
        file_waddr_nxt = file_waddr_r;
        done_nxt = op_valid;
        if (op_valid)
        begin
            file_waddr_nxt = file_addr;
        end
    end

    // all outputs registered; write strobe and done last one cycle
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_r <= `LFA_ACC_RST;
            flags_r <= `LFA_FLAGS_RST;
            file_we_r <= 1'b0;
            file_waddr_r <= `LFA_ADDR_RST;
            file_wdata_r <= {WIDTH{1'b0}};
            done_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            file_we_r <= file_we_nxt;
            file_waddr_r <= file_waddr_nxt;
            file_wdata_r <= file_wdata_nxt;
            done_r <= done_nxt;
        end
    end
endmodule // lfa_alu

// *** dv/lfa_file_model.sv ***
// lfa_file_model.sv: behavioural file registers behind the alu
// assumes registered write strobe, address and data
module lfa_file_model(input wire ref_clk, file_we_r, input wire [6:0] file_addr,
    file_waddr_r, input wire [7:0] file_wdata_r, output wire [7:0] file_rdata);
    timeunit 1ns / 1ps;
    logic [7:0] mem [128];
    // the array only takes a write at the next edge, so a read of the
    // address being written must see the pending data instead
    assign file_rdata = (file_we_r && file_waddr_r == file_addr) ? file_wdata_r : mem[file_addr];
    initial foreach (mem[j]) mem[j] = 8'(j * 37);
    always @(posedge ref_clk) if (file_we_r) mem[file_waddr_r] <= file_wdata_r;
endmodule // lfa_file_model

// *** dv/lfa_alu_checker.sv ***
// lfa_alu_checker.sv: port assertions on the alu
// assumes default widths, bound onto lfa_alu
module lfa_alu_checker(input wire ref_clk, rst_n, op_valid, dest_sel, file_we_r,
    input wire [2:0] op_code, bit_sel, flags_r,
    input wire [7:0] literal, file_rdata, acc_r, file_wdata_r);
    timeunit 1ns / 1ps;
    // op one-hot, operands one edge back
    wire [7:0] a = {7'h0, op_valid} << op_code;
    logic [7:0] pa, pr, pk;
    logic [2:0] pf, pb;
    always @(posedge ref_clk) {pa, pr, pk, pf, pb} <= {acc_r, file_rdata, literal, flags_r, bit_sel};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_add_lit: assert property (a[1] |=> {flags_r[0], acc_r} == pa + pk)
        else $error("add lit");
    chk_add_file: assert property (a[2] && dest_sel |=> file_wdata_r == pa + pr)
        else $error("add file");
    chk_acc_dest: assert property (a[2] && !dest_sel |=> !file_we_r && acc_r == pa + pr)
        else $error("dest");
    chk_and_file: assert property (a[3] |=> flags_r[1:0] == pf[1:0])
        else $error("and file");
    chk_and_lit: assert property (a[4] |=> acc_r == (pa & pk))
        else $error("and lit");
    chk_bit_clr: assert property (a[5] |=> file_wdata_r == (pr & ~(8'h01 << pb)))
        else $error("clear");
    chk_bit_set: assert property (a[6] |=> flags_r == pf && file_wdata_r[pb])
        else $error("set");
    chk_dc_flag: assert property (a[1] |=> flags_r[1] == (pa[3:0] + pk[3:0] > 15))
        else $error("dc");
    cover property (a[2] && dest_sel);
    cover property (a[1] ##1 flags_r == 3'h7);
    cover property (a[5] ##1 a[6]);
endmodule // lfa_alu_checker
bind lfa_alu lfa_alu_checker chk(.*);

// *** dv/literal_file_alu_ops_bench.sv ***
// literal_file_alu_ops_bench.sv: random op stream into the alu
// assumes lfa_file_model holds the file registers
`define CMP(x, e) begin checks++; if ((x) !== (e)) begin n_errors++; \
$display("wrong value at %0t: got %0h expected %0h", $time, x, e); end end
module literal_file_alu_ops_bench;
    timeunit 1ns / 1ps;
    logic ref_clk = 0, rst_n = 0, op_valid = 0, dest_sel = 0, e_we = 0, e_dn = 0;
    logic [2:0] op_code = 0, bit_sel = 0, e_fl = 0;
    logic [7:0] literal = 0, e_acc = 0, e_wd, r;
    logic [6:0] file_addr = 0, e_wa = 0;
    logic pin_addr = 0;
    logic [9:0] s;
    wire [7:0] file_rdata, acc_r, file_wdata_r;
    wire [6:0] file_waddr_r;
    wire [2:0] flags_r;
    wire file_we_r, done_r;
    int seed = 27, n_errors = 0, checks = 0;
    always #20 ref_clk = ~ref_clk;
    lfa_alu uut(.*);
    lfa_file_model pm(.*);
    // {dc, c, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, b);
        return {a[3:0] + b[3:0] > 15, 9'(a) + b};
    endfunction
    // check last op, launch next back to back
    task automatic step(logic v, logic [2:0] c, logic [7:0] k, logic [2:0] b, logic d);
        @(posedge ref_clk);
        {op_valid, op_code, literal, bit_sel, dest_sel} <= {v, c, k, b, d};
        file_addr <= pin_addr ? file_addr : 7'($random(seed));
        #1;
        `CMP({acc_r, flags_r, done_r, file_we_r}, {e_acc, e_fl, e_dn, e_we})
        `CMP(file_waddr_r, e_wa)
        if (v) e_wa = file_addr;
        if (e_we) `CMP(file_wdata_r, e_wd)
        s = add8(e_acc, c == 1 ? k : file_rdata);
        r = c < 3 ? s[7:0] : c == 3 ? e_acc & file_rdata : c == 4 ? e_acc & k :
            c == 5 ? file_rdata & ~(8'h01 << b) : file_rdata | 8'h01 << b;
        {e_dn, e_we, e_wd} = {v, 1'b0, r};
        if (v && c % 7)
        begin
            e_we = c > 4 || c[1] && d;
            if (c < 3) e_fl[1:0] = s[9:8];
            if (c < 5) e_fl[2] = !r;
            if (!e_we) e_acc = r;
        end
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1;
        // every code at full scale, then zero and carry corners
        for (int i = 0; i < 8; i++) step(1, i, 8'hff, 7, 1);
        step(1, 4, 0, 0, 0);
        step(1, 1, 8'h0f, 0, 0);
        step(1, 1, 8'hf1, 0, 0);
        // one file register hit back to back while its write is pending
        pin_addr = 1;
        step(1, 6, 0, 3, 0);
        step(1, 5, 0, 3, 0);
        step(1, 2, 0, 0, 1);
        step(1, 3, 0, 0, 0);
        pin_addr = 0;
        repeat (400) step($random(seed), $random(seed), $random(seed), $random(seed), $random(seed));
        step(0, 0, 0, 0, 0);
        tally_and_finish;
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
endmodule // literal_file_alu_ops_bench
